// ===== rtl/reset_filter_regs.svh
`ifndef RESET_FILTER_REGS_SVH
`define RESET_FILTER_REGS_SVH

// ============================================================
// Register map (byte addresses, one aligned 32-bit word each)
`define REG_FILTER_CTRL_OFS     8'h00
`define REG_STATUS_OFS          8'h04
`define REG_ADDR_MSB            7

// ============================================================
// Filter control field positions and reset value
`define CTRL_FILTER_SEL_BIT     0
`define CTRL_SAMPLE_SEL_BIT     1
`define CTRL_RESET_VAL          8'h00

// ============================================================
// Status field positions
`define STAT_WRITTEN_BIT        0
`define STAT_DIGITAL_BIT        1
`define STAT_OSC_ALIVE_BIT      2
`define STAT_RAM_UNDEF_BIT      3
`define STAT_STATE_LSB          8
`define STAT_STATE_MSB          12

// ============================================================
// Sample counts
`define SAMPLES_LONG            5'h14
`define SAMPLES_SHORT           5'h0A

// ============================================================
// Timing
`define CLK_PERIOD_NS           4
`define OSC_LOSS_NS             400
`define OSC_LOSS_CYC            ((`OSC_LOSS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_BASE_LOG2_DEF    13

// ============================================================
// AXI responses
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// ===== rtl/reset_filter_pkg.sv
package reset_filter_pkg;

  // ============================================================
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_RUN    = 5'h01,  // Normal operation
    ST_RESET  = 5'h02,  // Pin held low, system in reset
    ST_SETTLE = 5'h04,  // Oscillator settling after release
    ST_STOP   = 5'h08,  // STOP mode, analog filter only
    ST_WAKE   = 5'h10   // Settling after wake from STOP
  } seq_state_t;

  // ============================================================
  // Filter control register contents
  typedef struct packed {
    logic sample_count_select;  // 1: 10 samples, 0: 20 samples
    logic filter_select;        // 1: digital plus analog
  } filter_ctrl_t;

  // ============================================================
  // Clock and function enables towards the rest of the chip
  typedef struct packed {
    logic osc_enable;           // Main oscillator runs
    logic sys_clock_enable;     // Internal system clock runs
    logic cpu_clock_enable;     // CPU clock runs
    logic periph_clock_enable;  // Peripheral clock chain runs
    logic periph_func_enable;   // Other peripheral functions may start
    logic wdt2_enable;          // Second watchdog runs
  } clk_enables_t;

endpackage

// ===== rtl/reset_pin_noise_filter.sv
// Contract
// R1: Pin low holds whole system in reset.
// R2: Main oscillator stopped while pin low.
// R3: Pin rising edge ends reset state.
// R4: Oscillator settle time before CPU runs.
// R5: System, CPU clocks restart at fxx/8.
// R6: Peripheral clocks start after settle time.
// R7: Peripheral registers init; watchdog two restarts.
// R8: RAM kept unless power-on or colliding write.
// R9: Other peripheral functions start after settle.
// R10: Filter select picks digital or analog path.
// R11: Sample with oscillator, 20 or 10 samples.
// R12: Control register byte wide, resets 00H.
// R13: Control register accepts first write only.
// R14: Stopped sampling clock forces analog filtering.
// R15: Internal reset reinitialises control register.
// R16: Analog only from STOP until settle done.
// R17: Analog only while subclock source selected.
// R18: Reject below (N-1)T, accept from NT.
// R19: N consecutive low samples, high restarts count.
// R20: Pin reset clears reset cause flags.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`include "reset_filter_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module reset_pin_noise_filter #(
  parameter int unsigned SETTLE_BASE_LOG2 = `SETTLE_BASE_LOG2_DEF  // Log2 of shortest settle length
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Pin and chip side
  input  wire logic                      reset_pin_n,
  input  wire logic                      main_osc_clock,
  input  wire logic [2:0]                osc_settle_select,
  input  wire logic                      clock_source_select,
  input  wire logic                      stop_mode,
  input  wire logic                      stop_wake,
  input  wire logic                      cpu_ram_write,
  output logic                           system_reset_n,
  output reset_filter_pkg::clk_enables_t clk_enables,
  output logic                           clock_div_init,
  output logic                           wdt2_use_internal_osc,
  output logic                           ram_write_block,
  output logic                           ram_contents_undefined,
  output logic                           reset_cause_clear,
  output logic                           reset_output_line
);

  // ============================================================
  // Helper functions

  // Sample count selected by the control register
  function automatic logic [4:0] sample_target(input logic short_sel);
    sample_target = short_sel ? `SAMPLES_SHORT : `SAMPLES_LONG;
  endfunction

  // Settle length in oscillator edges for a given selection
  function automatic logic [23:0] settle_len(input logic [2:0] sel);
    settle_len = 24'h000001 << (5'(SETTLE_BASE_LOG2) + {2'h0, sel});
  endfunction

  // ============================================================
  // Declarations
  logic                             pin_sync1_reg;      // First synchroniser stage
  logic                             pin_sync2_reg;      // Synchronised pin level
  logic                             osc_sync1_reg;      // First synchroniser stage
  logic                             osc_sync2_reg;      // Synchronised oscillator level
  logic                             osc_prev_reg;       // Previous oscillator level
  logic                             osc_tick;           // Rising oscillator edge
  logic [7:0]                       osc_idle_reg;       // Cycles since last oscillator edge
  logic [7:0]                       osc_idle_next;
  logic                             osc_alive;          // Sampling clock is running
  logic [4:0]                       low_cnt_reg;        // Consecutive low samples
  logic [4:0]                       low_cnt_next;
  logic                             digital_active;     // Digital filter in effect
  logic                             reset_request;      // Filtered reset demand
  reset_filter_pkg::seq_state_t     state_reg;
  reset_filter_pkg::seq_state_t     state_next;
  logic [23:0]                      settle_cnt_reg;     // Settle progress in oscillator edges
  logic [23:0]                      settle_cnt_next;
  reset_filter_pkg::filter_ctrl_t   ctrl_reg;           // Control register
  reset_filter_pkg::filter_ctrl_t   ctrl_next;
  logic                             written_reg;        // First write already taken
  logic                             written_next;
  logic                             ram_undef_reg;      // RAM content may be damaged
  logic                             ram_undef_next;
  logic                             reset_entry;        // Cycle that enters reset
  logic                             aw_got_reg;         // Write address held
  logic                             aw_got_next;
  logic [7:0]                       aw_addr_reg;
  logic [7:0]                       aw_addr_next;
  logic                             w_got_reg;          // Write data held
  logic                             w_got_next;
  logic [31:0]                      w_data_reg;
  logic [31:0]                      w_data_next;
  logic [3:0]                       w_strb_reg;
  logic [3:0]                       w_strb_next;
  logic                             bvalid_reg;
  logic                             bvalid_next;
  logic [1:0]                       bresp_reg;
  logic [1:0]                       bresp_next;
  logic                             rvalid_reg;
  logic                             rvalid_next;
  logic [31:0]                      rdata_reg;
  logic [31:0]                      rdata_next;
  logic [1:0]                       rresp_reg;
  logic [1:0]                       rresp_next;
  logic                             do_write;           // Both halves of a write present
  logic [31:0]                      status_word;

  // ============================================================
  // Synchronisers; the first stages feed only the second ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync1_reg <= 1'b1;
      pin_sync2_reg <= 1'b1;
      osc_sync1_reg <= 1'b0;
      osc_sync2_reg <= 1'b0;
      osc_prev_reg  <= 1'b0;
    end else begin
      pin_sync1_reg <= reset_pin_n;
      pin_sync2_reg <= pin_sync1_reg;
      osc_sync1_reg <= main_osc_clock;
      osc_sync2_reg <= osc_sync1_reg;
      osc_prev_reg  <= osc_sync2_reg;
    end
  end

  // Oscillator edge marks a sampling instant
  assign osc_tick = osc_sync2_reg & ~osc_prev_reg;  // see R11

  // ============================================================
  // Oscillator activity watch
  always_comb begin
    osc_idle_next = osc_idle_reg;
    if (osc_tick || !clk_enables.osc_enable) begin
      osc_idle_next = osc_tick ? 8'h00 : 8'(`OSC_LOSS_CYC);
    end else if (osc_idle_reg < 8'(`OSC_LOSS_CYC)) begin
      osc_idle_next = osc_idle_reg + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_idle_reg <= 8'(`OSC_LOSS_CYC);
    end else begin
      osc_idle_reg <= osc_idle_next;
    end
  end

  // A quiet oscillator means no samples, so the digital path cannot be trusted
  assign osc_alive = (osc_idle_reg < 8'(`OSC_LOSS_CYC));

  // Digital path only in normal main-clock operation with a live clock
  assign digital_active = ctrl_reg.filter_select                    // see R10
                        & osc_alive                                 // see R14
                        & (state_reg == reset_filter_pkg::ST_RUN)   // see R16
                        & ~clock_source_select;                     // see R17

  // ============================================================
  // Digital noise filter: counts consecutive low samples
  always_comb begin
    low_cnt_next = low_cnt_reg;
    if (!digital_active) begin
      low_cnt_next = 5'h00;
    end else if (osc_tick) begin
      if (pin_sync2_reg) begin
        low_cnt_next = 5'h00;  // see R19
      end else if (low_cnt_reg < sample_target(ctrl_reg.sample_count_select)) begin
        low_cnt_next = low_cnt_reg + 5'h01;  // see R11
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_reg <= 5'h00;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end

  // Pulses shorter than N samples never fill the count
  assign reset_request = digital_active
                       ? (low_cnt_reg == sample_target(ctrl_reg.sample_count_select))  // see R18
                       : ~pin_sync2_reg;                                               // see R10

  // ============================================================
  // Reset sequencer
  always_comb begin
    state_next      = state_reg;
    settle_cnt_next = settle_cnt_reg;
    case (state_reg)
      reset_filter_pkg::ST_RUN: begin
        if (reset_request) begin
          state_next = reset_filter_pkg::ST_RESET;  // see R1
        end else if (stop_mode) begin
          state_next = reset_filter_pkg::ST_STOP;
        end
      end
      reset_filter_pkg::ST_RESET: begin
        // Release on pin high; oscillator stopped
        if (pin_sync2_reg) begin
          state_next      = reset_filter_pkg::ST_SETTLE;  // see R3
          settle_cnt_next = 24'h000000;
        end
      end
      reset_filter_pkg::ST_SETTLE: begin
        if (reset_request) begin
          state_next = reset_filter_pkg::ST_RESET;
        end else if (osc_tick) begin
          if (settle_cnt_reg + 24'h000001 >= settle_len(osc_settle_select)) begin
            state_next = reset_filter_pkg::ST_RUN;  // see R4
          end
          settle_cnt_next = settle_cnt_reg + 24'h000001;
        end
      end
      reset_filter_pkg::ST_STOP: begin
        if (reset_request) begin
          state_next = reset_filter_pkg::ST_RESET;
        end else if (stop_wake) begin
          state_next      = reset_filter_pkg::ST_WAKE;
          settle_cnt_next = 24'h000000;
        end
      end
      reset_filter_pkg::ST_WAKE: begin
        // Analog filter until settled
        if (reset_request) begin
          state_next = reset_filter_pkg::ST_RESET;
        end else if (osc_tick) begin
          if (settle_cnt_reg + 24'h000001 >= settle_len(osc_settle_select)) begin
            state_next = reset_filter_pkg::ST_RUN;  // see R16
          end
          settle_cnt_next = settle_cnt_reg + 24'h000001;
        end
      end
      default: begin
        state_next      = reset_filter_pkg::ST_RESET;
        settle_cnt_next = 24'h000000;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= reset_filter_pkg::ST_RESET;
      settle_cnt_reg <= 24'h000000;
    end else begin
      state_reg      <= state_next;
      settle_cnt_reg <= settle_cnt_next;
    end
  end

  // Entry into reset from any other state
  assign reset_entry = (state_next == reset_filter_pkg::ST_RESET) && (state_reg != reset_filter_pkg::ST_RESET);

  // ============================================================
  // Chip-side outputs, decoded from the state flops except the RAM flag and the fixed WDT2 source
  always_comb begin
    system_reset_n                  = (state_reg != reset_filter_pkg::ST_RESET);  // see R1
    clk_enables.osc_enable          = (state_reg != reset_filter_pkg::ST_RESET);  // see R2
    clk_enables.sys_clock_enable    = (state_reg == reset_filter_pkg::ST_RUN);    // see R5
    clk_enables.cpu_clock_enable    = (state_reg == reset_filter_pkg::ST_RUN);    // see R4
    clk_enables.periph_clock_enable = (state_reg == reset_filter_pkg::ST_RUN);    // see R6
    clk_enables.periph_func_enable  = (state_reg == reset_filter_pkg::ST_RUN);    // see R9
    clk_enables.wdt2_enable         = (state_reg != reset_filter_pkg::ST_RESET);  // see R7
    clock_div_init                  = (state_reg == reset_filter_pkg::ST_RESET)
                                    | (state_reg == reset_filter_pkg::ST_SETTLE); // see R5
    wdt2_use_internal_osc           = 1'b1;                                        // see R7
    ram_write_block                 = (state_reg == reset_filter_pkg::ST_RESET);  // see R8
    reset_output_line               = (state_reg != reset_filter_pkg::ST_RESET);
    ram_contents_undefined          = ram_undef_reg;
  end

  // ============================================================
  // RAM damage flag and reset-cause clear pulse
  always_comb begin
    ram_undef_next = ram_undef_reg;
    if (do_write && (aw_addr_reg[`REG_ADDR_MSB:0] == `REG_STATUS_OFS)
        && w_strb_reg[0] && w_data_reg[`STAT_RAM_UNDEF_BIT]) begin
      ram_undef_next = 1'b0;
    end
    // A write colliding with reset entry wins over a clear
    if (reset_entry && cpu_ram_write) begin
      ram_undef_next = 1'b1;  // see R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_undef_reg     <= 1'b1;  // Power-on leaves RAM undefined
      reset_cause_clear <= 1'b0;
    end else begin
      ram_undef_reg     <= ram_undef_next;
      reset_cause_clear <= reset_entry;  // see R20
    end
  end

  // ============================================================
  // Filter control register, write once per reset
  always_comb begin
    ctrl_next    = ctrl_reg;
    written_next = written_reg;
    if (do_write && (aw_addr_reg[`REG_ADDR_MSB:0] == `REG_FILTER_CTRL_OFS)
        && w_strb_reg[0] && !written_reg) begin
      ctrl_next.filter_select       = w_data_reg[`CTRL_FILTER_SEL_BIT];  // see R12
      ctrl_next.sample_count_select = w_data_reg[`CTRL_SAMPLE_SEL_BIT];
      written_next                  = 1'b1;                              // see R13
    end
    // Internal reset: analog-only, register reopened
    if (state_reg == reset_filter_pkg::ST_RESET) begin
      ctrl_next    = reset_filter_pkg::filter_ctrl_t'(2'(`CTRL_RESET_VAL));  // see R15
      written_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg    <= reset_filter_pkg::filter_ctrl_t'(2'(`CTRL_RESET_VAL));  // see R12
      written_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      written_reg <= written_next;
    end
  end

  // ============================================================
  // AXI4-Lite write channel: address and data taken in any order
  assign s_axi_awready = ~aw_got_reg;
  assign s_axi_wready  = ~w_got_reg;
  assign do_write      = aw_got_reg & w_got_reg & ~bvalid_reg;

  always_comb begin
    aw_got_next  = aw_got_reg;
    aw_addr_next = aw_addr_reg;
    w_got_next   = w_got_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && !aw_got_reg) begin
      aw_got_next  = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_reg) begin
      w_got_next  = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      // Unmapped addresses answer with a slave error
      bvalid_next = 1'b1;
      bresp_next  = ((aw_addr_reg == `REG_FILTER_CTRL_OFS) || (aw_addr_reg == `REG_STATUS_OFS))
                  ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_got_reg   <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
    end else begin
      aw_got_reg  <= aw_got_next;
      aw_addr_reg <= aw_addr_next;
      w_got_reg   <= w_got_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ============================================================
  // Status word
  always_comb begin
    status_word                                       = 32'h00000000;
    status_word[`STAT_WRITTEN_BIT]                    = written_reg;
    status_word[`STAT_DIGITAL_BIT]                    = digital_active;
    status_word[`STAT_OSC_ALIVE_BIT]                  = osc_alive;
    status_word[`STAT_RAM_UNDEF_BIT]                  = ram_undef_reg;
    status_word[`STAT_STATE_MSB:`STAT_STATE_LSB]      = state_reg;
  end

  // ============================================================
  // AXI4-Lite read channel: one read at a time
  assign s_axi_arready = ~rvalid_reg;

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = `RESP_OKAY;
      case (s_axi_araddr)
        `REG_FILTER_CTRL_OFS: begin
          rdata_next = {30'h00000000, ctrl_reg};  // see R12
        end
        `REG_STATUS_OFS: begin
          rdata_next = status_word;
        end
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule

`default_nettype wire

// ===== verification/reset_filter_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ======
// Sequencing checks
module reset_filter_asserts (
  input wire logic                           aclk,
  input wire logic                           aresetn,
  input wire logic                           reset_pin_n,
  input wire logic                           system_reset_n,
  input wire reset_filter_pkg::clk_enables_t clk_enables,
  input wire logic                           clock_div_init,
  input wire logic                           reset_cause_clear,
  input wire logic                           reset_output_line
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin high, still held; sync plus state take three edges
  sequence held_rel;
    (!system_reset_n && reset_pin_n) [*3];
  endsequence
  a_osc_stop_reset: assert property (!system_reset_n |-> !clk_enables.osc_enable) else $error("osc on");
  a_cpu_stop_reset: assert property (!system_reset_n |-> !clk_enables.cpu_clock_enable
    && !clk_enables.sys_clock_enable) else $error("cpu clock on");
  a_periph_after_settle: assert property (clk_enables.periph_clock_enable |-> system_reset_n
    && !clock_div_init) else $error("periph early");
  a_func_with_periph: assert property (clk_enables.periph_func_enable == clk_enables.periph_clock_enable)
    else $error("func early");
  a_wdt_two_stop: assert property (clk_enables.wdt2_enable == system_reset_n) else $error("wdt2");
  a_pin_out_low: assert property (reset_output_line == system_reset_n) else $error("out line");
  a_cause_one_pulse: assert property (reset_cause_clear |-> !system_reset_n ##1 !reset_cause_clear)
    else $error("cause clear");
  a_release_ends: assert property (held_rel |=> system_reset_n ##0 clock_div_init) else $error("no release");
endmodule
bind reset_pin_noise_filter reset_filter_asserts chk (.aclk, .aresetn, .reset_pin_n, .system_reset_n,
  .clk_enables, .clock_div_init, .reset_cause_clear, .reset_output_line);
`default_nettype wire

// ===== verification/reset_pin_source.sv
`timescale 1ns/1ns
`default_nettype none
// ======
// Pin driver and oscillator
module reset_pin_source (
  input  wire logic aclk,
  input  wire logic osc_on,
  output var logic  reset_pin_n,
  output var logic  main_osc_clock
);
  logic [1:0] div_reg;  // Half period counter
  initial begin
    reset_pin_n = 1'b1;
    main_osc_clock = 1'b0;
    div_reg = 2'h0;
  end
  // Still while held off
  always @(posedge aclk) if (osc_on) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3) main_osc_clock <= !main_osc_clock;
  end
  // Low pulse of n cycles on the pin
  task automatic pulse(input int n);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge aclk);
    reset_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== verification/reset_pin_noise_filter_bench.sv
`timescale 1ns/1ns
`default_nettype none
// ======
// Bench
module reset_pin_noise_filter_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clock_source_select;
  logic        reset_pin_n, main_osc_clock, system_reset_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, lfsr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  osc_settle_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];  // Expected {rresp, rdata}
  int          err_count, comparisons, cycles, t;
  reset_filter_pkg::clk_enables_t clk_enables;
  reset_pin_source src (.aclk, .osc_on(clk_enables.osc_enable), .reset_pin_n, .main_osc_clock);
  reset_pin_noise_filter #(.SETTLE_BASE_LOG2(2)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .reset_pin_n, .main_osc_clock, .osc_settle_select, .clock_source_select, .stop_mode(1'b0),
    .stop_wake(1'b0), .cpu_ram_write(1'b0), .system_reset_n, .clk_enables, .clock_div_init(),
    .wdt2_use_internal_osc(), .ram_write_block(), .ram_contents_undefined(), .reset_cause_clear(),
    .reset_output_line());
  initial begin
    aclk = 1'b0;
    forever #2 aclk = !aclk;
  end
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("Counts: %0d checks, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      test_done();
    end
  end
  // Read answers against oldest note
  always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] d);
    logic aw, w;
    {aw, w} = 2'h3;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {8'h00, d, 4'h1};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      {s_axi_awvalid, s_axi_wvalid} <= {aw, w};
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // Cycles until CPU clock runs
  task automatic wait_run;
    t = 0;
    while (clk_enables.cpu_clock_enable !== 1'b1) begin
      @(posedge aclk);
      t++;
    end
  endtask
  // Pulse, then reset must hold
  task automatic hit(input int n, input string nm);
    src.pulse(n);
    chk(nm, {33'h0, system_reset_n}, 34'h0);
    wait_run();
    chk("settle", {33'h0, t >= ((32'h1 << (osc_settle_select + 2)) - 1) * 8}, 34'h1);
    $display("Test %s done", nm);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, clock_source_select} = '0;
    {err_count, comparisons, cycles} = '0;
    lfsr = nxt(8'h1F);
    osc_settle_select = lfsr[2:0];
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run();
    rd(8'h00, 34'h0);
    rd(8'h08, {2'h2, 32'h0});
    lfsr = nxt(lfsr);
    wr({lfsr, 24'h000003});
    wr(32'h0);
    rd(8'h00, 34'h3);
    src.pulse(64);
    repeat (8) @(posedge aclk);
    chk("short pulse", {33'h0, system_reset_n}, 34'h1);
    hit(96, "digital");
    rd(8'h00, 34'h0);
    hit(6, "analog");
    wr({nxt(lfsr), 24'h000001});
    rd(8'h00, 34'h1);
    clock_source_select <= 1'b1;
    @(posedge aclk);
    hit(6, "subclock");
    test_done();
  end
endmodule
`default_nettype wire
